// ### verilog/gauge_alarm_map.svh
`ifndef GAUGE_ALARM_MAP_SVH
`define GAUGE_ALARM_MAP_SVH

// Register addresses (one-byte index, 16-bit data)
`define REG_STATUS 8'h00
`define REG_SETUP 8'h01
`define REG_INT_FLAGS 8'h02
`define REG_INT_MASK 8'h03
`define REG_INT_CLEAR 8'h04
`define REG_RISE_LIMIT 8'h05
`define REG_FALL_LIMIT 8'h06
`define REG_FS_MARGIN 8'h07
`define REG_UV_SET 8'h08
`define REG_UV_CLEAR 8'h09
`define REG_TEMP_MAX 8'h0a
`define REG_TEMP_MIN 8'h0b
`define REG_LOW_THRESH 8'h0c
`define REG_HIGH_THRESH 8'h0d
`define REG_RUNTIME_IN 8'h0e
`define REG_FAULT_REASON 8'h0f
`define REG_USER_LEVEL 8'h10
`define REG_IDLE_TIME 8'h11
`define REG_IDLE_CURRENT 8'h12
`define REG_OFF_CURRENT 8'h13

// Setup word fields
`define SETUP_RUN_BIT 0
`define SETUP_REF_BIT 1

// Runtime input fields
`define RUNTIME_CHG_BIT 0
`define RUNTIME_BAT_BIT 1

// Status word fields
`define ST_CHG_BIT 0
`define ST_BAT_BIT 1
`define ST_DIS_BIT 2
`define ST_UV_BIT 3
`define ST_OT_BIT 4
`define ST_UT_BIT 5
`define ST_ZERO_BIT 6
`define ST_LOW_BIT 7
`define ST_HIGH_BIT 8
`define ST_FAULT_BIT 9
`define ST_ACT_LSB 10

// Interrupt flag positions
`define FLG_OT 0
`define FLG_UV 2
`define FLG_HIGH 3
`define FLG_UT 4
`define FLG_BOUNDS 6
`define FLG_ZERO 7
`define FLG_LOW_SET 8
`define FLG_LOW_CLR 9
`define FLG_WDT 12

// Reset values
`define MASK_RST 16'h0000
`define SETUP_RST 16'h0000
`define RISE_RST 16'h0001
`define FALL_RST 16'h0001
`define MARGIN_RST 16'h0000
`define HIGH_RST 16'h0064
`define TMAX_RST 16'h7fff
`define TMIN_RST 16'h8000
`define IDLE_TIME_RST 16'h0006

// Timing
`define CORE_CLK_HZ 25000000
`define ACQ_ACTIVE_S 10
`define ACQ_ACTIVE_CYCLES (`ACQ_ACTIVE_S * `CORE_CLK_HZ)
`define WDT_TIMEOUT_S 2
`define WDT_CYCLES (`WDT_TIMEOUT_S * `CORE_CLK_HZ)
`define FULL_LEVEL 8'h64

`endif

// ### verilog/gauge_alarm_pkg.sv
package gauge_alarm_pkg;

    typedef enum logic [2:0] {
        ACT_ACTIVE = 3'b001,
        ACT_RESTING = 3'b010,
        ACT_OFF = 3'b100
    } activity_e;

    typedef struct packed {
        logic [15:0] setup;
        logic [15:0] flags;
        logic [15:0] mask;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] margin;
        logic [15:0] uv_set;
        logic [15:0] uv_clr;
        logic [15:0] tmax;
        logic [15:0] tmin;
        logic [15:0] low_thr;
        logic [15:0] high_thr;
        logic [15:0] idle_time;
        logic [15:0] idle_cur;
        logic [15:0] off_cur;
        logic [15:0] idle_cnt;
        logic [15:0] cur_abs;
        logic [15:0] rdata;
        logic [31:0] acq_cnt;
        logic [31:0] wdt_cnt;
        logic [7:0] reason;
        logic [7:0] user;
        activity_e activity;
        logic chg;
        logic bat;
        logic dis;
        logic chgg;
        logic uv;
        logic ot;
        logic ut;
        logic zero;
        logic low;
        logic high;
        logic fault;
        logic hib;
        logic int_oe;
        logic acq_tick;
    } gauge_s;

endpackage : gauge_alarm_pkg

// ### verilog/gauge_alarm_interrupt_logic.sv
// Summary of operation
// - Without charger at the last measurement the battery never counts as charging; user level never rises.
// - Each update moves user level by at most rise or fall limit.
// - User level reads full once relative level reaches full minus margin.
// - After charger removal user level falls with load even above full threshold.
// - Undervolt alarm sets below set level, clears only above clear level.
// - Undervolt alarm entry sets flag bit 2 and interrupts.
// - Temperature above max sets bit 0, below min sets bit 4.
// - Selected level reaching zero while discharging sets bit 7.
// - Selected level reaching low threshold while discharging sets bit 8.
// - Selected level rising above low threshold while charging sets bit 9.
// - High alarm sets at or above threshold, clears one percent below.
// - High alarm entry sets flag bit 3.
// - Bounds fault sets bit 6, keeps reason, stops gauging, enters hibernate.
// - Charger and battery present bits mirror the host runtime input.
// - Discharging status bit follows negative battery current.
// - Activity field codes 11 active, 10 resting, 01 off.
// - Resting and off states slow the acquisition tick.
// - Watchdog expiry without engine progress sets the watchdog flag.
// - Interrupt pin is pulled low while any unmasked flag is pending.
// - Writing one to a clear bit clears that flag; zeros are ignored.
// - All interrupts enabled after reset; mask bits disable single sources.
// - Sixteen sources share bit positions across flag, mask, clear registers.
// - Registers are 16 bits wide at one-byte addresses.
`timescale 1ns/100ps
`default_nettype none
`include "gauge_alarm_map.svh"

module gauge_alarm_interrupt_logic
    import gauge_alarm_pkg::*;
#(
    parameter int unsigned ACQ_CYCLES = `ACQ_ACTIVE_CYCLES,
    parameter int unsigned WDT_CYCLES = `WDT_CYCLES
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [15:0] O_REG_RDATA,
    input wire logic I_MEAS_VALID,
    input wire logic [15:0] I_MEAN_CELL_VOLTAGE,
    input wire logic [15:0] I_SELECTED_TEMP_READING,
    input wire logic [15:0] I_BATTERY_CURRENT,
    input wire logic I_EST_VALID,
    input wire logic [7:0] I_RELATIVE_CHARGE_LEVEL,
    input wire logic [7:0] I_LOAD_DROP,
    input wire logic I_BOUNDS_FAULT,
    input wire logic [7:0] I_FAULT_REASON,
    input wire logic I_ENGINE_BEAT,
    input wire logic [15:0] I_EVENTS,
    output logic O_INT_N_O,
    output logic O_INT_N_OE,
    output logic [7:0] O_USER_CHARGE_LEVEL,
    output logic O_GAUGE_RUN,
    output logic O_HIBERNATE,
    output logic O_ACQ_TICK
);

    gauge_s st_q;
    gauge_s st_d;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [15:0] rd_v;
    logic [7:0] tgt_v;
    logic [7:0] down_v;
    logic [7:0] sel_v;
    logic run_v;
    logic hot_v;
    logic cold_v;

    function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
        min8 = (a < b) ? a : b;
    endfunction : min8

    // Scale relative level so the top margin maps onto full
    function automatic logic [7:0] scale(input logic [7:0] r, input logic [7:0] m);
        logic [7:0] top;
        logic [15:0] prod;
        top = (m >= `FULL_LEVEL) ? 8'h01 : 8'(`FULL_LEVEL - m);
        prod = 16'(r) * 16'(`FULL_LEVEL);
        scale = (r >= top) ? `FULL_LEVEL : 8'(prod / 16'(top));
    endfunction : scale

    function automatic logic [31:0] period(input activity_e a);
        case (a)
            ACT_RESTING: period = 32'(ACQ_CYCLES * 2);
            ACT_OFF: period = 32'(ACQ_CYCLES * 4);
            default: period = 32'(ACQ_CYCLES);
        endcase
    endfunction : period

    function automatic logic [1:0] act_code(input activity_e a, input logic run);
        case (a)
            ACT_ACTIVE: act_code = 2'b11;
            ACT_RESTING: act_code = 2'b10;
            ACT_OFF: act_code = 2'b01;
            default: act_code = 2'b00;
        endcase
        if (!run)
        begin
            act_code = 2'b00;
        end
    endfunction : act_code

    function automatic logic [15:0] abs16(input logic [15:0] v);
        abs16 = v[15] ? 16'(-v) : v;
    endfunction : abs16

    always_comb
    begin
        rd_v = 16'h0000;
        if (I_REG_ADDR == `REG_STATUS)
        begin
            rd_v[`ST_CHG_BIT] = st_q.chg;
            rd_v[`ST_BAT_BIT] = st_q.bat;
            rd_v[`ST_DIS_BIT] = st_q.dis;
            rd_v[`ST_UV_BIT] = st_q.uv;
            rd_v[`ST_OT_BIT] = st_q.ot;
            rd_v[`ST_UT_BIT] = st_q.ut;
            rd_v[`ST_ZERO_BIT] = st_q.zero;
            rd_v[`ST_LOW_BIT] = st_q.low;
            rd_v[`ST_HIGH_BIT] = st_q.high;
            rd_v[`ST_FAULT_BIT] = st_q.fault;
            rd_v[`ST_ACT_LSB +: 2] = act_code(st_q.activity, st_q.setup[`SETUP_RUN_BIT]);
        end
        else if (I_REG_ADDR == `REG_SETUP) rd_v = st_q.setup;
        else if (I_REG_ADDR == `REG_INT_FLAGS) rd_v = st_q.flags;
        else if (I_REG_ADDR == `REG_INT_MASK) rd_v = st_q.mask;
        else if (I_REG_ADDR == `REG_RISE_LIMIT) rd_v = st_q.rise;
        else if (I_REG_ADDR == `REG_FALL_LIMIT) rd_v = st_q.fall;
        else if (I_REG_ADDR == `REG_FS_MARGIN) rd_v = st_q.margin;
        else if (I_REG_ADDR == `REG_UV_SET) rd_v = st_q.uv_set;
        else if (I_REG_ADDR == `REG_UV_CLEAR) rd_v = st_q.uv_clr;
        else if (I_REG_ADDR == `REG_TEMP_MAX) rd_v = st_q.tmax;
        else if (I_REG_ADDR == `REG_TEMP_MIN) rd_v = st_q.tmin;
        else if (I_REG_ADDR == `REG_LOW_THRESH) rd_v = st_q.low_thr;
        else if (I_REG_ADDR == `REG_HIGH_THRESH) rd_v = st_q.high_thr;
        else if (I_REG_ADDR == `REG_RUNTIME_IN) rd_v = {14'h0000, st_q.bat, st_q.chg};
        else if (I_REG_ADDR == `REG_FAULT_REASON) rd_v = {8'h00, st_q.reason};
        else if (I_REG_ADDR == `REG_USER_LEVEL) rd_v = {8'h00, st_q.user};
        else if (I_REG_ADDR == `REG_IDLE_TIME) rd_v = st_q.idle_time;
        else if (I_REG_ADDR == `REG_IDLE_CURRENT) rd_v = st_q.idle_cur;
        else if (I_REG_ADDR == `REG_OFF_CURRENT) rd_v = st_q.off_cur;
    end

    always_comb
    begin
        st_d = st_q;
        set_v = I_EVENTS;
        clr_v = 16'h0000;
        tgt_v = 8'h00;
        down_v = 8'h00;
        hot_v = 1'b0;
        cold_v = 1'b0;
        run_v = st_q.setup[`SETUP_RUN_BIT];
        sel_v = st_q.setup[`SETUP_REF_BIT] ? st_q.user : I_RELATIVE_CHARGE_LEVEL;
        st_d.acq_tick = 1'b0;
        if (I_REG_RD)
        begin
            st_d.rdata = rd_v;
        end
        if (I_REG_WR)
        begin
            if (I_REG_ADDR == `REG_SETUP)
            begin
                st_d.setup = I_REG_WDATA;
                if (I_REG_WDATA[`SETUP_RUN_BIT])
                begin
                    st_d.hib = 1'b0;
                    st_d.fault = 1'b0;
                end
            end
            else if (I_REG_ADDR == `REG_INT_MASK) st_d.mask = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_INT_CLEAR) clr_v = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_RISE_LIMIT) st_d.rise = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_FALL_LIMIT) st_d.fall = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_FS_MARGIN) st_d.margin = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_UV_SET) st_d.uv_set = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_UV_CLEAR) st_d.uv_clr = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_TEMP_MAX) st_d.tmax = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_TEMP_MIN) st_d.tmin = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_LOW_THRESH) st_d.low_thr = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_HIGH_THRESH) st_d.high_thr = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_IDLE_TIME) st_d.idle_time = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_IDLE_CURRENT) st_d.idle_cur = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_OFF_CURRENT) st_d.off_cur = I_REG_WDATA;
            else if (I_REG_ADDR == `REG_RUNTIME_IN)
            begin
                st_d.chg = I_REG_WDATA[`RUNTIME_CHG_BIT];
                st_d.bat = I_REG_WDATA[`RUNTIME_BAT_BIT];
            end
        end
        if (I_MEAS_VALID && run_v)
        begin
            st_d.dis = I_BATTERY_CURRENT[15];
            st_d.chgg = st_q.chg && !I_BATTERY_CURRENT[15] && (I_BATTERY_CURRENT != 16'h0000);
            st_d.cur_abs = abs16(I_BATTERY_CURRENT);
            if (!st_q.uv && (I_MEAN_CELL_VOLTAGE < st_q.uv_set))
            begin
                st_d.uv = 1'b1;
                set_v[`FLG_UV] = 1'b1;
            end
            else if (st_q.uv && (I_MEAN_CELL_VOLTAGE > st_q.uv_clr))
            begin
                st_d.uv = 1'b0;
            end
            hot_v = $signed(I_SELECTED_TEMP_READING) > $signed(st_q.tmax);
            cold_v = $signed(I_SELECTED_TEMP_READING) < $signed(st_q.tmin);
            set_v[`FLG_OT] = set_v[`FLG_OT] | (hot_v & ~st_q.ot);
            set_v[`FLG_UT] = set_v[`FLG_UT] | (cold_v & ~st_q.ut);
            st_d.ot = hot_v;
            st_d.ut = cold_v;
        end
        if (I_EST_VALID && run_v)
        begin
            tgt_v = scale(I_RELATIVE_CHARGE_LEVEL, st_q.margin[7:0]);
            if (st_q.chgg)
            begin
                if (tgt_v > st_q.user)
                begin
                    st_d.user = st_q.user + min8(tgt_v - st_q.user, st_q.rise[7:0]);
                end
            end
            else
            begin
                down_v = (tgt_v < st_q.user) ? 8'(st_q.user - tgt_v) : 8'h00;
                if (st_q.dis && !st_q.chg && (I_LOAD_DROP > down_v))
                begin
                    down_v = I_LOAD_DROP;
                end
                down_v = min8(min8(down_v, st_q.fall[7:0]), st_q.user);
                st_d.user = st_q.user - down_v;
            end
            if ((sel_v == 8'h00) && st_q.dis)
            begin
                st_d.zero = 1'b1;
                set_v[`FLG_ZERO] = set_v[`FLG_ZERO] | ~st_q.zero;
            end
            else if (sel_v != 8'h00)
            begin
                st_d.zero = 1'b0;
            end
            if (!st_q.low && st_q.dis && (sel_v <= st_q.low_thr[7:0]))
            begin
                st_d.low = 1'b1;
                set_v[`FLG_LOW_SET] = 1'b1;
            end
            else if (st_q.low && st_q.chgg && (sel_v > st_q.low_thr[7:0]))
            begin
                st_d.low = 1'b0;
                set_v[`FLG_LOW_CLR] = 1'b1;
            end
            if (!st_q.high && (sel_v >= st_q.high_thr[7:0]))
            begin
                st_d.high = 1'b1;
                set_v[`FLG_HIGH] = 1'b1;
            end
            else if (st_q.high && ({1'b0, sel_v} + 9'h001 <= {1'b0, st_q.high_thr[7:0]}))
            begin
                st_d.high = 1'b0;
            end
        end
        // Acquisition divider, slowed outside the active state
        if (!run_v)
        begin
            st_d.acq_cnt = 32'h0000_0000;
            st_d.idle_cnt = 16'h0000;
            st_d.activity = ACT_ACTIVE;
        end
        else if (st_q.acq_cnt >= period(st_q.activity) - 32'h0000_0001)
        begin
            st_d.acq_cnt = 32'h0000_0000;
            st_d.acq_tick = 1'b1;
            if (st_q.cur_abs >= st_q.idle_cur)
            begin
                st_d.idle_cnt = 16'h0000;
                st_d.activity = ACT_ACTIVE;
            end
            else if (st_q.idle_cnt < st_q.idle_time)
            begin
                st_d.idle_cnt = st_q.idle_cnt + 16'h0001;
            end
            else
            begin
                st_d.activity = (st_q.cur_abs < st_q.off_cur) ? ACT_OFF : ACT_RESTING;
            end
        end
        else
        begin
            st_d.acq_cnt = st_q.acq_cnt + 32'h0000_0001;
        end
        if (!run_v || I_ENGINE_BEAT)
        begin
            st_d.wdt_cnt = 32'h0000_0000;
        end
        else if (st_q.wdt_cnt >= WDT_CYCLES - 1)
        begin
            st_d.wdt_cnt = 32'h0000_0000;
            set_v[`FLG_WDT] = 1'b1;
        end
        else
        begin
            st_d.wdt_cnt = st_q.wdt_cnt + 32'h0000_0001;
        end
        if (I_BOUNDS_FAULT && run_v)
        begin
            set_v[`FLG_BOUNDS] = 1'b1;
            st_d.reason = I_FAULT_REASON;
            st_d.setup[`SETUP_RUN_BIT] = 1'b0;
            st_d.hib = 1'b1;
            st_d.fault = 1'b1;
        end
        st_d.flags = (st_q.flags & ~clr_v) | set_v;
        st_d.int_oe = |(st_d.flags & ~st_d.mask);
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_N)
        begin
            st_q <= '0;
            st_q.activity <= ACT_ACTIVE;
            st_q.mask <= `MASK_RST;
            st_q.setup <= `SETUP_RST;
            st_q.rise <= `RISE_RST;
            st_q.fall <= `FALL_RST;
            st_q.margin <= `MARGIN_RST;
            st_q.high_thr <= `HIGH_RST;
            st_q.tmax <= `TMAX_RST;
            st_q.tmin <= `TMIN_RST;
            st_q.idle_time <= `IDLE_TIME_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign O_REG_RDATA = st_q.rdata;
    assign O_INT_N_O = 1'b0;
    assign O_INT_N_OE = st_q.int_oe;
    assign O_USER_CHARGE_LEVEL = st_q.user;
    assign O_GAUGE_RUN = st_q.setup[`SETUP_RUN_BIT];
    assign O_HIBERNATE = st_q.hib;
    assign O_ACQ_TICK = st_q.acq_tick;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    int_pull_a: assert property ((|(st_q.flags & ~st_q.mask)) |-> O_INT_N_OE)
        else $error("pending unmasked flag without pin pull");
    int_masked_a: assert property (((st_q.flags & ~st_q.mask) == 16'h0000) |-> !O_INT_N_OE)
        else $error("pin pulled with no unmasked flag");
    clear_bit_a: assert property ((I_REG_WR && I_REG_ADDR == `REG_INT_CLEAR && I_REG_WDATA[`FLG_UV]
        && !I_EVENTS[`FLG_UV] && !I_MEAS_VALID) |=> !st_q.flags[`FLG_UV])
        else $error("write one did not clear flag");
    no_rise_a: assert property ((!st_q.chgg && !st_q.chg) |=> (st_q.user <= $past(st_q.user)))
        else $error("user level rose without charger");
    fall_step_a: assert property ((st_q.user < $past(st_q.user))
        |-> ($past(st_q.user) - st_q.user <= $past(st_q.fall[7:0])))
        else $error("user level fell beyond limit");
    uv_entry_a: assert property ($rose(st_q.uv) |-> st_q.flags[`FLG_UV])
        else $error("undervolt entry without flag");
    high_entry_a: assert property ($rose(st_q.high) |-> st_q.flags[`FLG_HIGH])
        else $error("high alarm entry without flag");
    fault_stop_a: assert property ((I_BOUNDS_FAULT && O_GAUGE_RUN)
        |=> (O_HIBERNATE && !O_GAUGE_RUN && st_q.flags[`FLG_BOUNDS] && st_q.reason == $past(I_FAULT_REASON)))
        else $error("bounds fault did not halt gauging");
    wdt_fire_a: assert property ((O_GAUGE_RUN && !I_ENGINE_BEAT && !I_BOUNDS_FAULT && !I_REG_WR
        && st_q.wdt_cnt == WDT_CYCLES - 1) |=> st_q.flags[`FLG_WDT])
        else $error("watchdog expiry without flag");

endmodule : gauge_alarm_interrupt_logic
`default_nettype wire

// ### bench/gauge_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module gauge_host_model
(
    input wire logic i_int_n_o,
    input wire logic i_int_n_oe,
    output logic o_int_line
);
    // Pull-up wins whenever the gauge lets go of the line
    assign o_int_line = i_int_n_oe ? i_int_n_o : 1'b1;
endmodule : gauge_host_model

`default_nettype wire

// ### bench/test_gauge_alarm_interrupt_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "gauge_alarm_map.svh"

module test_gauge_alarm_interrupt_logic;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic mv = 1'b0;
    logic ev = 1'b0;
    logic flt = 1'b0;
    logic beat = 1'b0;
    logic beat_en = 1'b1;
    logic [15:0] volt = 16'h0e00;
    logic [15:0] temp = 16'h0020;
    logic [15:0] cur = 16'h0000;
    logic [7:0] rel = 8'h00;
    logic [7:0] drop = 8'h00;
    logic [7:0] reason = 8'h00;
    logic [15:0] evts = 16'h0000;
    logic [15:0] rdata;
    logic int_o, int_oe, int_line, run, hib, tick;
    logic [7:0] user;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;

    always #20 clk = ~clk;
    always @(posedge clk) beat <= beat_en;

    gauge_alarm_interrupt_logic #(.ACQ_CYCLES(8), .WDT_CYCLES(20)) u_dut (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_MEAS_VALID(mv),
        .I_MEAN_CELL_VOLTAGE(volt), .I_SELECTED_TEMP_READING(temp), .I_BATTERY_CURRENT(cur),
        .I_EST_VALID(ev), .I_RELATIVE_CHARGE_LEVEL(rel), .I_LOAD_DROP(drop),
        .I_BOUNDS_FAULT(flt), .I_FAULT_REASON(reason), .I_ENGINE_BEAT(beat), .I_EVENTS(evts),
        .O_INT_N_O(int_o), .O_INT_N_OE(int_oe), .O_USER_CHARGE_LEVEL(user),
        .O_GAUGE_RUN(run), .O_HIBERNATE(hib), .O_ACQ_TICK(tick));

    gauge_host_model u_host (.i_int_n_o(int_o), .i_int_n_oe(int_oe), .o_int_line(int_line));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    // Read and compare the masked word
    task automatic reg_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & m, e);
    endtask : reg_chk

    task automatic meas(input logic [15:0] v, input logic [15:0] t, input logic [15:0] c);
        @(posedge clk);
        volt <= v;
        temp <= t;
        cur <= c;
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
    endtask : meas

    task automatic est(input logic [7:0] r, input logic [7:0] l);
        @(posedge clk);
        rel <= r;
        drop <= l;
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
    endtask : est

    // Cycles between two acquisition ticks, sampled where settled
    task automatic tick_gap(input int lim, output int n);
        n = 0;
        while (tick !== 1'b1 && n < lim)
        begin
            n++;
            @(negedge clk);
        end
        n = 1;
        @(negedge clk);
        while (tick !== 1'b1 && n < lim)
        begin
            n++;
            @(negedge clk);
        end
    endtask : tick_gap

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        reg_chk(`REG_INT_MASK, 16'hffff, 16'h0000);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0000);
        reg_chk(`REG_HIGH_THRESH, 16'hffff, 16'h0064);
        reg_chk(8'hff, 16'hffff, 16'h0000);
        reg_wr(`REG_SETUP, 16'h0001);
        reg_wr(`REG_RUNTIME_IN, 16'h0002);
        reg_chk(`REG_STATUS, 16'h0c03, 16'h0c02);
        chk({15'h0000, run}, 16'h0001);
        tick_gap(20, n);
        chk(16'(n), 16'h0008);
        // Idle current above the measured one: resting, then off
        reg_wr(`REG_IDLE_TIME, 16'h0001);
        reg_wr(`REG_IDLE_CURRENT, 16'h0010);
        repeat (40) @(posedge clk);
        reg_chk(`REG_STATUS, 16'h0c00, 16'h0800);
        tick_gap(40, n);
        chk(16'(n), 16'h0010);
        reg_wr(`REG_OFF_CURRENT, 16'h0010);
        repeat (40) @(posedge clk);
        reg_chk(`REG_STATUS, 16'h0c00, 16'h0400);
        tick_gap(40, n);
        chk(16'(n), 16'h0020);
        // Undervoltage hysteresis and clearing
        reg_wr(`REG_UV_SET, 16'h0c80);
        reg_wr(`REG_UV_CLEAR, 16'h0d00);
        meas(16'h0c00, 16'h0020, 16'hff00);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0004);
        reg_chk(`REG_STATUS, 16'h000c, 16'h000c);
        chk({15'h0000, int_line}, 16'h0000);
        reg_wr(`REG_INT_CLEAR, 16'h0000);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0004);
        reg_wr(`REG_INT_CLEAR, 16'h0004);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0000);
        chk({15'h0000, int_line}, 16'h0001);
        meas(16'h0c00, 16'h0020, 16'hff00);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0000);
        meas(16'h0cc0, 16'h0020, 16'hff00);
        reg_chk(`REG_STATUS, 16'h0008, 16'h0008);
        meas(16'h0d40, 16'h0020, 16'hff00);
        reg_chk(`REG_STATUS, 16'h0008, 16'h0000);
        // Temperature bounds
        reg_wr(`REG_TEMP_MAX, 16'h003c);
        reg_wr(`REG_TEMP_MIN, 16'hfff6);
        meas(16'h0e00, 16'h0046, 16'hff00);
        meas(16'h0e00, 16'hfff0, 16'hff00);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0011);
        reg_wr(`REG_INT_CLEAR, 16'h0001);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0010);
        reg_wr(`REG_INT_CLEAR, 16'h0010);
        // Masked source still records
        reg_wr(`REG_INT_MASK, 16'h0001);
        reg_chk(`REG_INT_MASK, 16'hffff, 16'h0001);
        meas(16'h0e00, 16'h0046, 16'hff00);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0001);
        chk({15'h0000, int_line}, 16'h0001);
        reg_wr(`REG_INT_MASK, 16'h0000);
        reg_chk(`REG_INT_CLEAR, 16'hffff, 16'h0000);
        chk({15'h0000, int_line}, 16'h0000);
        reg_wr(`REG_INT_CLEAR, 16'h0001);
        @(posedge clk);
        evts <= 16'h8000;
        @(posedge clk);
        evts <= 16'h0000;
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h8000);
        reg_wr(`REG_INT_CLEAR, 16'h8000);
        reg_wr(`REG_INT_FLAGS, 16'hffff);
        reg_chk(`REG_INT_FLAGS, 16'hffff, 16'h0000);
        // User level shaping, referenced to user level
        reg_wr(`REG_SETUP, 16'h0003);
        reg_wr(`REG_RUNTIME_IN, 16'h0003);
        reg_wr(`REG_RISE_LIMIT, 16'h000a);
        reg_wr(`REG_FALL_LIMIT, 16'h0005);
        reg_wr(`REG_FS_MARGIN, 16'h0002);
        meas(16'h0e00, 16'h0020, 16'h0100);
        repeat (9) est(8'h62, 8'h00);
        @(negedge clk);
        chk({8'h00, user}, 16'h005a);
        repeat (3) est(8'h62, 8'h00);
        @(negedge clk);
        chk({8'h00, user}, 16'h0064);
        reg_chk(`REG_INT_FLAGS, 16'h0008, 16'h0008);
        reg_wr(`REG_RUNTIME_IN, 16'h0002);
        meas(16'h0e00, 16'h0020, 16'hff00);
        est(8'h62, 8'h03);
        @(negedge clk);
        chk({8'h00, user}, 16'h0061);
        est(8'h64, 8'h00);
        @(negedge clk);
        chk({8'h00, user}, 16'h0061);
        // Low and zero alarms on relative level
        reg_wr(`REG_SETUP, 16'h0001);
        reg_wr(`REG_LOW_THRESH, 16'h0014);
        reg_wr(`REG_INT_CLEAR, 16'hffff);
        est(8'h14, 8'h00);
        reg_chk(`REG_INT_FLAGS, 16'h0180, 16'h0100);
        est(8'h00, 8'h00);
        reg_chk(`REG_INT_FLAGS, 16'h0180, 16'h0180);
        reg_wr(`REG_RUNTIME_IN, 16'h0003);
        meas(16'h0e00, 16'h0020, 16'h0100);
        est(8'h1e, 8'h00);
        reg_chk(`REG_INT_FLAGS, 16'h0200, 16'h0200);
        // Engine stalls, then a bounds fault
        beat_en <= 1'b0;
        repeat (30) @(posedge clk);
        reg_chk(`REG_INT_FLAGS, 16'h1000, 16'h1000);
        beat_en <= 1'b1;
        @(posedge clk);
        reason <= 8'h5a;
        flt <= 1'b1;
        @(posedge clk);
        flt <= 1'b0;
        reg_chk(`REG_INT_FLAGS, 16'h0040, 16'h0040);
        reg_chk(`REG_FAULT_REASON, 16'h00ff, 16'h005a);
        chk({15'h0000, hib}, 16'h0001);
        chk({15'h0000, run}, 16'h0000);
        give_verdict();
    end
endmodule : test_gauge_alarm_interrupt_logic

`default_nettype wire
